// ---- core/uie_pkg.sv ----
// constants for the serial port interrupt enable and event identification block
package uie_pkg;
  localparam logic [2:0] UIE_OFS_DATA = 3'h0;
  localparam logic [2:0] UIE_OFS_IER = 3'h1;
  localparam logic [2:0] UIE_OFS_EIR_FCR = 3'h2;
  localparam logic [2:0] UIE_OFS_LSR = 3'h5;
  localparam logic [2:0] UIE_OFS_MSR = 3'h6;
  localparam int UIE_IE_RX = 0;
  localparam int UIE_IE_TXLOW = 1;
  localparam int UIE_IE_LS = 2;
  localparam int UIE_IE_MS = 3;
  localparam int UIE_IE_TXEMP = 5;
  localparam logic [7:0] UIE_IER_RESET = 8'h00;
  localparam logic [7:0] UIE_IER_MASK_EXT = 8'h2f;
  localparam logic [7:0] UIE_IER_MASK_STD = 8'h0f;
  localparam int UIE_FCR_FIFO_EN = 0;
  localparam logic [7:0] UIE_FCR_RESET = 8'h00;
  localparam logic [3:0] UIE_CODE_NONE = 4'h1;
  localparam logic [3:0] UIE_CODE_LS = 4'h6;
  localparam logic [3:0] UIE_CODE_RXLVL = 4'h4;
  localparam logic [3:0] UIE_CODE_RXTO = 4'hc;
  localparam logic [3:0] UIE_CODE_TXLOW = 4'h2;
  localparam logic [3:0] UIE_CODE_MS = 4'h0;
  localparam logic [7:0] UIE_RD_RESET = 8'h00;
endpackage

// ---- core/uie_core.sv ----
// interrupt enable, event identification and interrupt request logic of a serial port
// Behaviour
// - extended mode: enable bit 1 gates transmit low-level interrupt
// - line status interrupts only with enable bit 2, reset cleared
// - modem status interrupts only with enable bit 3, reset cleared
// - extended mode: enable bit 5 gates transmitter-and-fifo empty interrupt
// - identification read and fifo control write share one address
// - non-extended mode reports only highest of five priority levels
// - bit 0 reads 0 when pending, 1 when idle
// - bits 2,1 encode highest pending interrupt, default 00
// - bit 3 zero without fifos, set for highest-priority receive timeout
// - bits 7,6 mirror fifo enable in non-extended mode
// - code 0110 on receive errors, cleared by line status read
// - code 0100 on receive data level, clears when data drains
// - code 1100 on receive timeout, cleared by receive data read
// - code 0010 on transmit empty, cleared by identification read or data write
// - code 0000 on modem line change, cleared by modem status read
// - extended mode: separate pending flags regardless of enables
// - extended bit 0: receive data present or level or timeout
// - extended bit 1: transmit holder empty or fifo below threshold
// - extended bit 2: receive error or break reported
// - extended bit 3: any of four modem change bits set
// - extended bit 5: mirrors transmitter completely empty
`timescale 1ns/100ps
module uie_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] cpuAddr,
  input wire logic cpuRd,
  input wire logic cpuWr,
  input wire logic [7:0] cpuWrData,
  input wire logic extendedModeSelect,
  input wire logic rxDataReady,
  input wire logic rxTimeout,
  input wire logic txLowLevel,
  input wire logic txEmpty,
  input wire logic lineErrorEvent,
  input wire logic [3:0] msrDelta,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic fifoCtrlWrite,
  output logic [7:0] fifoCtrlData,
  output logic fifoEnabled,
  output logic irq
);
  import uie_pkg::*;

  // priority encoder over enabled sources
  function automatic logic [3:0] prioCode(input logic ls, input logic rxTo, input logic rxLvl,
                                          input logic tx, input logic ms);
    if (ls) begin
      prioCode = UIE_CODE_LS;
    end else if (rxTo) begin
      prioCode = UIE_CODE_RXTO;
    end else if (rxLvl) begin
      prioCode = UIE_CODE_RXLVL;
    end else if (tx) begin
      prioCode = UIE_CODE_TXLOW;
    end else if (ms) begin
      prioCode = UIE_CODE_MS;
    end else begin
      prioCode = UIE_CODE_NONE;
    end
  endfunction

  logic [7:0] ierReg, ierNext;
  logic [7:0] fcrReg, fcrNext;
  logic lsPendReg, lsPendNext;
  logic txPendReg, txPendNext;
  logic txLowPrevReg, txLowPrevNext;
  logic [7:0] rdDataReg, rdDataNext;
  logic rdValidReg, rdValidNext;
  logic fcrWrReg, fcrWrNext;
  logic irqReg, irqNext;
  logic fifoOn, rxToEv, rxHighEv, msEv;
  logic enLs, enRxTo, enRxLvl, enTx, enMs, enTxEmp;
  logic [3:0] code;
  logic [7:0] eirStd, eirExt;
  logic rdEir, rdLsr, wrIer, wrFcr, wrData;

  always_comb begin
    fifoOn = fcrReg[UIE_FCR_FIFO_EN];
    rdEir = cpuRd && (cpuAddr == UIE_OFS_EIR_FCR);
    rdLsr = cpuRd && (cpuAddr == UIE_OFS_LSR);
    wrIer = cpuWr && (cpuAddr == UIE_OFS_IER);
    wrFcr = cpuWr && (cpuAddr == UIE_OFS_EIR_FCR);
    wrData = cpuWr && (cpuAddr == UIE_OFS_DATA);
    rxToEv = rxTimeout && fifoOn;
    rxHighEv = rxDataReady || rxToEv;
    msEv = |msrDelta;
    enLs = lsPendReg && ierReg[UIE_IE_LS];
    enRxTo = rxToEv && ierReg[UIE_IE_RX];
    enRxLvl = rxDataReady && ierReg[UIE_IE_RX];
    enTx = (extendedModeSelect ? txLowLevel : txPendReg) && ierReg[UIE_IE_TXLOW];
    enMs = msEv && ierReg[UIE_IE_MS];
    enTxEmp = extendedModeSelect && txEmpty && ierReg[UIE_IE_TXEMP];
    code = prioCode(enLs, enRxTo, enRxLvl, enTx, enMs);
    eirStd = {{2{fifoOn}}, 2'b00, code};
    eirExt = {2'b00, txEmpty, 1'b0, msEv, lsPendReg, txLowLevel, rxHighEv};
  end

  always_comb begin
    ierNext = ierReg;
    fcrNext = fcrReg;
    lsPendNext = lsPendReg;
    txPendNext = txPendReg;
    txLowPrevNext = txLowLevel;
    rdDataNext = rdDataReg;
    rdValidNext = 1'b0;
    fcrWrNext = wrFcr;
    if (wrIer) begin
      ierNext = cpuWrData & (extendedModeSelect ? UIE_IER_MASK_EXT : UIE_IER_MASK_STD);
    end else if (!extendedModeSelect) begin
      ierNext = ierReg & UIE_IER_MASK_STD;
    end
    if (wrFcr) begin
      fcrNext = cpuWrData;
    end
    if (lineErrorEvent) begin
      lsPendNext = 1'b1;
    end else if (rdLsr) begin
      lsPendNext = 1'b0;
    end
    if ((txLowLevel && !txLowPrevReg) ||
        (wrIer && cpuWrData[UIE_IE_TXLOW] && !ierReg[UIE_IE_TXLOW] && txLowLevel)) begin
      txPendNext = 1'b1;
    end else if (wrData || !txLowLevel) begin
      txPendNext = 1'b0;
    end else if (rdEir && !extendedModeSelect && code == UIE_CODE_TXLOW) begin
      txPendNext = 1'b0;
    end
    if (cpuRd && cpuAddr == UIE_OFS_IER) begin
      rdDataNext = ierReg;
      rdValidNext = 1'b1;
    end else if (rdEir) begin
      rdDataNext = extendedModeSelect ? eirExt : eirStd;
      rdValidNext = 1'b1;
    end
    irqNext = enLs || enRxTo || enRxLvl || enTx || enMs || enTxEmp;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ierReg <= UIE_IER_RESET;
      fcrReg <= UIE_FCR_RESET;
      lsPendReg <= 1'b0;
      txPendReg <= 1'b0;
      txLowPrevReg <= 1'b0;
      rdDataReg <= UIE_RD_RESET;
      rdValidReg <= 1'b0;
      fcrWrReg <= 1'b0;
      irqReg <= 1'b0;
    end else begin
      ierReg <= ierNext;
      fcrReg <= fcrNext;
      lsPendReg <= lsPendNext;
      txPendReg <= txPendNext;
      txLowPrevReg <= txLowPrevNext;
      rdDataReg <= rdDataNext;
      rdValidReg <= rdValidNext;
      fcrWrReg <= fcrWrNext;
      irqReg <= irqNext;
    end
  end

  assign rdData = rdDataReg;
  assign rdValid = rdValidReg;
  assign fifoCtrlWrite = fcrWrReg;
  assign fifoCtrlData = fcrReg;
  assign fifoEnabled = fcrReg[UIE_FCR_FIFO_EN];
  assign irq = irqReg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_ls_gate;
    !ierReg[UIE_IE_LS] && lsPendReg && ierReg == 8'h00 |=> !irq;
  endproperty
  a_ls_gate: assert property (p_ls_gate) else $error("line status irq while disabled");

  property p_ms_irq;
    (msEv && ierReg[UIE_IE_MS])[*2] |-> irq;
  endproperty
  a_ms_irq: assert property (p_ms_irq) else $error("enabled modem event gave no irq");

  property p_txemp_irq;
    extendedModeSelect && txEmpty && ierReg[UIE_IE_TXEMP] |=> irq;
  endproperty
  a_txemp_irq: assert property (p_txemp_irq) else $error("transmitter empty irq missing");

  property p_fcr_write;
    wrFcr |=> fifoCtrlWrite && fifoCtrlData == $past(cpuWrData) && !rdValid;
  endproperty
  a_fcr_write: assert property (p_fcr_write) else $error("fifo control write not taken");

  property p_idle_code;
    rdEir && !extendedModeSelect && !irqNext |=> rdValid && rdData[3:0] == 4'h1;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("idle code not 0001");

  property p_fen;
    rdEir && !extendedModeSelect |=> rdData[7:6] == {2{fifoEnabled}} && rdData[5:4] == 2'b00;
  endproperty
  a_fen: assert property (p_fen) else $error("fifo enabled bits wrong");

  property p_no_to_wo_fifo;
    rdEir && !extendedModeSelect && !fifoOn && !wrFcr |=> !rdData[3];
  endproperty
  a_no_to_wo_fifo: assert property (p_no_to_wo_fifo) else $error("timeout bit with fifos off");

  property p_ls_top;
    rdEir && !extendedModeSelect && enLs |=> rdData[3:0] == 4'h6;
  endproperty
  a_ls_top: assert property (p_ls_top) else $error("line status not highest");

  property p_ls_clear;
    rdLsr && !lineErrorEvent |=> !lsPendReg && !enLs;
  endproperty
  a_ls_clear: assert property (p_ls_clear) else $error("line status read did not clear");

  property p_tx_clear;
    wrData && !(txLowLevel && !txLowPrevReg) && !wrIer |=> !txPendReg;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("data write did not clear transmit flag");

  property p_ext_flags;
    rdEir && extendedModeSelect |=> rdData[5] == $past(txEmpty) && rdData[3] == $past(msEv) && rdData[4] == 1'b0;
  endproperty
  a_ext_flags: assert property (p_ext_flags) else $error("extended flags wrong");

  property p_txlow_ext;
    extendedModeSelect && txLowLevel && ierReg[UIE_IE_TXLOW] |=> irq;
  endproperty
  a_txlow_ext: assert property (p_txlow_ext) else $error("transmit low irq missing");

  property p_rxto_rank;
    rdEir && !extendedModeSelect && enRxTo && !enLs |=> rdData[3:0] == 4'hc;
  endproperty
  a_rxto_rank: assert property (p_rxto_rank) else $error("timeout code wrong");

  property p_rxlvl_code;
    rdEir && !extendedModeSelect && !enLs && !enRxTo && enRxLvl |=> rdData[3:0] == 4'h4;
  endproperty
  a_rxlvl_code: assert property (p_rxlvl_code) else $error("receive level code wrong");

  property p_tx_code;
    rdEir && !wrIer && !extendedModeSelect && txPendReg && ierReg[UIE_IE_TXLOW] && !enLs && !enRxTo && !enRxLvl
      |=> rdData[3:0] == 4'h2 && !txPendReg;
  endproperty
  a_tx_code: assert property (p_tx_code) else $error("transmit code or its clear wrong");

  property p_ms_code;
    rdEir && !extendedModeSelect && enMs && !enLs && !enRxTo && !enRxLvl && !enTx |=> rdData[3:0] == 4'h0;
  endproperty
  a_ms_code: assert property (p_ms_code) else $error("modem code wrong");

  property p_pend_bit;
    rdEir && !extendedModeSelect && (enLs || enRxTo || enRxLvl || enTx || enMs) |=> !rdData[0];
  endproperty
  a_pend_bit: assert property (p_pend_bit) else $error("pending bit not low");

  property p_ext_rx;
    rdEir && extendedModeSelect |=> rdData[0] == $past(rxDataReady || (rxTimeout && fifoEnabled));
  endproperty
  a_ext_rx: assert property (p_ext_rx) else $error("extended receive flag wrong");

  property p_ext_txlow;
    rdEir && extendedModeSelect |=> rdData[1] == $past(txLowLevel);
  endproperty
  a_ext_txlow: assert property (p_ext_txlow) else $error("extended transmit flag wrong");

  property p_ext_ls;
    rdEir && extendedModeSelect |=> rdData[2] == $past(lsPendReg);
  endproperty
  a_ext_ls: assert property (p_ext_ls) else $error("extended line flag wrong");

  property p_ls_set;
    lineErrorEvent |=> lsPendReg;
  endproperty
  a_ls_set: assert property (p_ls_set) else $error("line error not latched");

  property p_irq_drop;
    !lsPendReg && !msEv && !txLowLevel && !txEmpty && !rxDataReady && !rxTimeout |=> !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq without pending event");

  property p_ier_mask;
    !extendedModeSelect |=> ierReg[7:4] == 4'h0;
  endproperty
  a_ier_mask: assert property (p_ier_mask) else $error("extended enables kept");

  property p_eir_rd_only;
    rdEir && !cpuWr |=> !fifoCtrlWrite && fifoCtrlData == $past(fifoCtrlData);
  endproperty
  a_eir_rd_only: assert property (p_eir_rd_only) else $error("ident read touched fifo control");

  c_rxto_read: cover property (rdEir && enRxTo ##1 rdData[3:0] == 4'hc);
  c_ls_read: cover property (lineErrorEvent ##[1:4] rdEir ##1 rdData[3:0] == 4'h6);
  c_tx_clear: cover property (txPendReg && rdEir ##1 !txPendReg);
  c_ext_read: cover property (extendedModeSelect && rdEir ##1 rdData != 8'h00);
  c_irq_rise: cover property (!irq ##1 irq);
endmodule // uie_core

// ---- tb/uie_far_model.sv ----
// far-side model: modem change bits and receive fifo timeout source
`timescale 1ns/100ps
module uie_far_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] cpuAddr,
  input wire logic cpuRd,
  input wire logic modemChange,
  input wire logic rxStall,
  output logic [3:0] msrDelta,
  output logic rxTimeout
);
  import uie_pkg::*;
  logic [3:0] delta_reg;
  logic [3:0] delta_next;
  logic timeout_reg;
  logic timeout_next;
  always_comb begin
    delta_next = delta_reg;
    timeout_next = timeout_reg;
    if (cpuRd && cpuAddr == UIE_OFS_MSR) delta_next = 4'h0;
    if (cpuRd && cpuAddr == UIE_OFS_DATA) timeout_next = 1'b0;
    if (modemChange) delta_next = 4'h5;
    if (rxStall) timeout_next = 1'b1;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      delta_reg <= 4'h0;
      timeout_reg <= 1'b0;
    end else begin
      delta_reg <= delta_next;
      timeout_reg <= timeout_next;
    end
  end
  assign msrDelta = delta_reg;
  assign rxTimeout = timeout_reg;
endmodule // uie_far_model

// ---- tb/uart_interrupt_enable_identify_tb.sv ----
// self-checking bench for the interrupt enable and identification block
`timescale 1ns/100ps
module uart_interrupt_enable_identify_tb;
  import uie_pkg::*;
  logic clk, reset, cpuRd, cpuWr, extendedModeSelect, rxDataReady, txLowLevel, txEmpty, lineErrorEvent;
  logic modemChange, rxStall, rdValid, fifoCtrlWrite, fifoEnabled, irq, rxTimeout;
  logic [2:0] cpuAddr;
  logic [7:0] cpuWrData, rdData, fifoCtrlData;
  logic [3:0] msrDelta;
  int num_errors = 0;
  int checked = 0;
  uie_core dut_u (.clk(clk), .reset(reset), .cpuAddr(cpuAddr), .cpuRd(cpuRd), .cpuWr(cpuWr),
    .cpuWrData(cpuWrData), .extendedModeSelect(extendedModeSelect), .rxDataReady(rxDataReady),
    .rxTimeout(rxTimeout), .txLowLevel(txLowLevel), .txEmpty(txEmpty), .lineErrorEvent(lineErrorEvent),
    .msrDelta(msrDelta), .rdData(rdData), .rdValid(rdValid), .fifoCtrlWrite(fifoCtrlWrite),
    .fifoCtrlData(fifoCtrlData), .fifoEnabled(fifoEnabled), .irq(irq));
  uie_far_model far_u (.clk(clk), .reset(reset), .cpuAddr(cpuAddr), .cpuRd(cpuRd),
    .modemChange(modemChange), .rxStall(rxStall), .msrDelta(msrDelta), .rxTimeout(rxTimeout));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cpuAddr = a;
    cpuWrData = d;
    cpuWr = 1'b1;
    cyc(1);
    cpuWr = 1'b0;
    if (a == UIE_OFS_EIR_FCR) chk("fifoCtrlWrite", 8'h01, {7'h00, fifoCtrlWrite});
    cyc(1);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    cpuAddr = a;
    cpuRd = 1'b1;
    cyc(1);
    cpuRd = 1'b0;
    if (a == UIE_OFS_IER || a == UIE_OFS_EIR_FCR) begin
      chk("rdValid", 8'h01, {7'h00, rdValid});
      chk("rdData", e, rdData);
    end
    cyc(1);
  endtask
  task automatic pulse_line();
    lineErrorEvent = 1'b1;
    cyc(1);
    lineErrorEvent = 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {reset, cpuRd, cpuWr, extendedModeSelect, rxDataReady, txLowLevel, txEmpty, lineErrorEvent} = 8'h80;
    {modemChange, rxStall, cpuAddr, cpuWrData} = 13'h0000;
    cyc(4);
    reset = 1'b0;
    rd(UIE_OFS_IER, 8'h00);
    rd(UIE_OFS_EIR_FCR, 8'h01);
    pulse_line();
    cyc(3);
    chk("irq", 8'h00, {7'h00, irq});
    wr(UIE_OFS_IER, 8'h04);
    cyc(2);
    chk("irq", 8'h01, {7'h00, irq});
    rd(UIE_OFS_EIR_FCR, 8'h06);
    txLowLevel = 1'b1;
    wr(UIE_OFS_IER, 8'h06);
    rd(UIE_OFS_EIR_FCR, 8'h06);
    rd(UIE_OFS_LSR, 8'h00);
    rd(UIE_OFS_EIR_FCR, 8'h02);
    rd(UIE_OFS_EIR_FCR, 8'h01);
    cyc(2);
    chk("irq", 8'h00, {7'h00, irq});
    modemChange = 1'b1;
    wr(UIE_OFS_IER, 8'h08);
    modemChange = 1'b0;
    rd(UIE_OFS_EIR_FCR, 8'h00);
    rd(UIE_OFS_MSR, 8'h00);
    rd(UIE_OFS_EIR_FCR, 8'h01);
    rxDataReady = 1'b1;
    rxStall = 1'b1;
    wr(UIE_OFS_IER, 8'h01);
    rxStall = 1'b0;
    rd(UIE_OFS_EIR_FCR, 8'h04);
    wr(UIE_OFS_EIR_FCR, 8'h01);
    chk("fifoEnabled", 8'h01, {7'h00, fifoEnabled});
    chk("fifoCtrlData", 8'h01, fifoCtrlData);
    rd(UIE_OFS_EIR_FCR, 8'hcc);
    rd(UIE_OFS_DATA, 8'h00);
    rd(UIE_OFS_EIR_FCR, 8'hc4);
    rxDataReady = 1'b0;
    rd(UIE_OFS_EIR_FCR, 8'hc1);
    extendedModeSelect = 1'b1;
    txLowLevel = 1'b1;
    txEmpty = 1'b1;
    wr(UIE_OFS_IER, 8'hff);
    rd(UIE_OFS_IER, 8'h2f);
    wr(UIE_OFS_IER, 8'h00);
    rd(UIE_OFS_EIR_FCR, 8'h22);
    chk("irq", 8'h00, {7'h00, irq});
    wr(UIE_OFS_IER, 8'h20);
    cyc(2);
    chk("irq", 8'h01, {7'h00, irq});
    wr(UIE_OFS_IER, 8'h02);
    cyc(2);
    chk("irq", 8'h01, {7'h00, irq});
    txLowLevel = 1'b0;
    cyc(3);
    chk("irq", 8'h00, {7'h00, irq});
    rxDataReady = 1'b1;
    modemChange = 1'b1;
    pulse_line();
    modemChange = 1'b0;
    cyc(2);
    rd(UIE_OFS_EIR_FCR, 8'h2d);
    finish_test();
  end
endmodule // uart_interrupt_enable_identify_tb
